// file: include/ledfp_pkg.sv
// shared constants and carrier types for the led driver fault sequencer
package ledfp_pkg;
	localparam int unsigned CLK_HZ             = 10_000_000;
	localparam int unsigned SHORT_BLANK_NS     = 175;
	localparam int unsigned LIMIT_BLANK_NS     = 275;
	localparam int unsigned AUX_OV_MIN_NS      = 1000;
	localparam int unsigned CLK_PERIOD_NS      = 1_000_000_000 / CLK_HZ;
	// blanking is a least time: round up
	localparam int unsigned SHORT_BLANK_CYC    =
		(SHORT_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned LIMIT_BLANK_CYC    =
		(LIMIT_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// "longer than" 1 us: one cycle past the rounded-up figure
	localparam int unsigned AUX_OV_CYC         =
		(AUX_OV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
	localparam int unsigned SLOW_TICK_US       = 1000;
	localparam int unsigned SLOW_TICK_CYC      =
		SLOW_TICK_US * (CLK_HZ / 1_000_000);
	localparam int unsigned RECOVERY_MS        = 4000;
	localparam int unsigned BROWNOUT_MS        = 25;
	localparam int unsigned FAULT_CYCLES       = 4;
	localparam int unsigned MAX_ON_US          = 36;
	localparam int unsigned MAX_ON_CYC         =
		MAX_ON_US * (CLK_HZ / 1_000_000);

	typedef enum logic [2:0] {
		LEDFP_ST_STARTUP = 3'b000,
		LEDFP_ST_CHECK   = 3'b001,
		LEDFP_ST_RUN     = 3'b011,
		LEDFP_ST_PAUSE   = 3'b010,
		LEDFP_ST_STOP    = 3'b110
	} ledfp_state_t;

	// comparator flags from the analog front end (asynchronous)
	typedef struct packed {
		logic short_trip;
		logic limit_trip;
		logic aux_over;
		logic supply_over;
		logic line_low;
		logic line_ok;
		logic supply_start;
		logic hot;
		logic cool;
		logic imp_low;
		logic imp_done;
	} ledfp_sense_t;

	typedef struct packed {
		logic gate_drive;
		logic imp_check;
		logic brownout_flag;
		logic startup_consumption;
		logic recovery_pause;
		logic stopped;
	} ledfp_status_t;
endpackage : ledfp_pkg

// file: design/ledfp_sync.sv
// two-stage synchroniser for a bundle of asynchronous levels
`timescale 1ns/100ps
module ledfp_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         core_clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_q;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : ledfp_sync

// file: design/ledfp_top.sv
// fault-protection sequencer of the led driver controller
`timescale 1ns/100ps
// Overview of operation
// - Short compare blanks 175 ns after turn-on, current limit 275 ns.
// - Four consecutive periods over the short threshold start auto-recovery.
// - Supply overvoltage stops gate pulses and starts auto-recovery.
// - After zero-crossing blanking, aux above 4.5 V over 1 us is an event.
// - Four consecutive cycles with aux events start auto-recovery.
// - Current limit trip ends the gate pulse for the rest of the cycle.
// - Line low for more than 25 ms raises the brown-out flag and stops.
// - Brown-out ends once line is above exit level and supply above start.
// - Brown-out exit goes to start-up consumption, restarts at start level.
// - Over-temperature stops operation until the cool release is seen.
// - Sense-pin check runs at start-up and after max on-time ends a pulse.
// - A sense-pin impedance at or below the short limit stops operation.
// - Auto-recovery issues no gate pulse until the 4 s delay has elapsed.
module ledfp_top
	import ledfp_pkg::*;
#(
	parameter int unsigned TICK_CYC    = SLOW_TICK_CYC,
	parameter int unsigned RECOVER_TKS = RECOVERY_MS,
	parameter int unsigned BROWN_TKS   = BROWNOUT_MS
) (
	input  wire logic          core_clk,
	input  wire logic          rst_b,
	input  wire logic          cycle_start,
	input  wire logic          zc_blank_done,
	input  wire ledfp_pkg::ledfp_sense_t sense,
	output ledfp_pkg::ledfp_status_t     status
);
	import ledfp_pkg::*;

	ledfp_sense_t s;
	ledfp_sync #(.W($bits(ledfp_sense_t))) u_sync (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.async_in (sense),
		.sync_out (s)
	);

	ledfp_state_t st_q, st_d;
	logic [22:0]  div_q;
	logic [11:0]  slow_q;
	logic [5:0]   brown_q;
	logic [9:0]   on_q;
	logic [3:0]   aux_q;
	logic [2:0]   sc_cnt_q, ov_cnt_q;
	logic         gate_q, sc_ev_q, ov_ev_q, brown_q_f, stop_cool_q;

	// slow timebase: one-cycle pulse per millisecond
	wire tick      = (div_q == 23'(TICK_CYC - 1));
	wire in_run    = (st_q == LEDFP_ST_RUN);
	wire short_ok  = gate_q && (on_q >= 10'(SHORT_BLANK_CYC));
	wire limit_ok  = gate_q && (on_q >= 10'(LIMIT_BLANK_CYC));
	wire sc_hit    = short_ok && s.short_trip;
	wire limit_hit = limit_ok && s.limit_trip;
	wire max_on    = gate_q && (on_q == 10'(MAX_ON_CYC - 1));
	wire aux_hit   = (aux_q == 4'(AUX_OV_CYC - 1)) && s.aux_over;
	// cycle counts include the cycle now closing
	wire sc_trip   = cycle_start && sc_ev_q
		&& (sc_cnt_q == 3'(FAULT_CYCLES - 1));
	wire ov_trip   = cycle_start && ov_ev_q
		&& (ov_cnt_q == 3'(FAULT_CYCLES - 1));
	wire brown_hit = s.line_low && (brown_q == 6'(BROWN_TKS)) && tick;
	wire to_pause  = in_run && (sc_trip || ov_trip || s.supply_over);
	wire pause_end = (slow_q == 12'(RECOVER_TKS - 1)) && tick;
	wire hard_stop = s.hot || brown_q_f || brown_hit;
	// any reason to end or withhold the pulse this cycle
	wire gate_cut  = !in_run || to_pause || hard_stop || limit_hit || max_on;

	always_comb begin
		st_d = st_q;
		unique case (st_q)
			LEDFP_ST_STARTUP: begin
				if (hard_stop) st_d = LEDFP_ST_STOP;
				else if (s.supply_start) st_d = LEDFP_ST_CHECK;
			end
			LEDFP_ST_CHECK: begin
				if (hard_stop) st_d = LEDFP_ST_STOP;
				else if (s.imp_done)
					st_d = s.imp_low ? LEDFP_ST_STOP : LEDFP_ST_RUN;
			end
			LEDFP_ST_RUN: begin
				if (hard_stop) st_d = LEDFP_ST_STOP;
				else if (to_pause) st_d = LEDFP_ST_PAUSE;
				else if (max_on) st_d = LEDFP_ST_CHECK;
			end
			LEDFP_ST_PAUSE: begin
				if (hard_stop) st_d = LEDFP_ST_STOP;
				else if (pause_end) st_d = LEDFP_ST_STARTUP;
			end
			LEDFP_ST_STOP: begin
				// thermal waits for cool; brown-out waits for line and supply
				if (!stop_cool_q && !brown_q_f && !s.hot && !brown_hit)
					st_d = LEDFP_ST_STOP;
				if (stop_cool_q && s.cool && !hard_stop)
					st_d = LEDFP_ST_STARTUP;
				if (brown_q_f && s.line_ok && s.supply_start && !s.hot)
					st_d = LEDFP_ST_STARTUP;
			end
			default: st_d = LEDFP_ST_STOP;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q  <= LEDFP_ST_STARTUP;
			div_q <= '0;
		end else begin
			st_q  <= st_d;
			div_q <= tick ? '0 : div_q + 23'd1;
		end
	end

	// recovery pause timer in milliseconds
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) slow_q <= '0;
		else if (st_q != LEDFP_ST_PAUSE) slow_q <= '0;
		else if (tick) slow_q <= slow_q + 12'd1;
	end

	// brown-out qualification: line must stay low through the whole window
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			brown_q   <= '0;
			brown_q_f <= 1'b0;
		end else begin
			if (!s.line_low) brown_q <= '0;
			else if (tick && brown_q != 6'(BROWN_TKS)) brown_q <= brown_q + 6'd1;
			if (brown_hit) brown_q_f <= 1'b1;
			else if (s.line_ok && s.supply_start) brown_q_f <= 1'b0;
		end
	end

	// remembers whether the stop was thermal
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) stop_cool_q <= 1'b0;
		else if (s.hot) stop_cool_q <= 1'b1;
		else if (s.cool) stop_cool_q <= 1'b0;
	end

	// gate pulse: opens at cycle start, ends on limit, max on-time, pause or stop
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			gate_q <= 1'b0;
			on_q   <= '0;
		end else begin
			if (gate_cut) gate_q <= 1'b0;
			else if (cycle_start) gate_q <= 1'b1;
			if (cycle_start || !gate_q) on_q <= '0;
			else on_q <= on_q + 10'd1;
		end
	end

	// per-cycle event capture and consecutive counts
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			aux_q    <= '0;
			sc_ev_q  <= 1'b0;
			ov_ev_q  <= 1'b0;
			sc_cnt_q <= '0;
			ov_cnt_q <= '0;
		end else begin
			if (!(zc_blank_done && s.aux_over && !gate_q)) aux_q <= '0;
			else if (!aux_hit) aux_q <= aux_q + 4'd1;
			if (to_pause || !in_run) begin
				sc_cnt_q <= '0;
				ov_cnt_q <= '0;
				sc_ev_q  <= 1'b0;
				ov_ev_q  <= 1'b0;
			end else if (cycle_start) begin
				sc_cnt_q <= sc_ev_q ? sc_cnt_q + 3'd1 : '0;
				ov_cnt_q <= ov_ev_q ? ov_cnt_q + 3'd1 : '0;
				sc_ev_q  <= sc_hit;
				ov_ev_q  <= aux_hit;
			end else begin
				if (sc_hit) sc_ev_q <= 1'b1;
				if (aux_hit) ov_ev_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) status <= '0;
		else begin
			// pin drops with the cut, never a cycle behind it
			status.gate_drive          <= gate_q && !gate_cut;
			status.imp_check           <= (st_d == LEDFP_ST_CHECK);
			status.brownout_flag       <= brown_q_f || brown_hit;
			status.startup_consumption <= (st_d == LEDFP_ST_STARTUP);
			status.recovery_pause      <= (st_d == LEDFP_ST_PAUSE);
			status.stopped             <= (st_d == LEDFP_ST_STOP);
		end
	end

	a_pause_no_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
		(st_q == LEDFP_ST_PAUSE) |=> !status.gate_drive)
		else $error("gate pulse during recovery pause");
	a_limit_ends: assert property (@(posedge core_clk) disable iff (!rst_b)
		limit_hit |=> !gate_q ##1 !status.gate_drive)
		else $error("gate not ended by current limit");
	a_short_blank: assert property (@(posedge core_clk) disable iff (!rst_b)
		$rose(gate_q) |-> !sc_hit [*1] ##1 !sc_hit)
		else $error("short compare inside blanking");
	a_limit_blank: assert property (@(posedge core_clk) disable iff (!rst_b)
		$rose(gate_q) |-> !limit_hit [*3])
		else $error("limit compare inside blanking");
	a_sc_pause: assert property (@(posedge core_clk) disable iff (!rst_b)
		(sc_trip && in_run && !hard_stop) |=> st_q == LEDFP_ST_PAUSE)
		else $error("short count did not pause");
	a_ov_pause: assert property (@(posedge core_clk) disable iff (!rst_b)
		(in_run && s.supply_over && !hard_stop) |=> st_q == LEDFP_ST_PAUSE)
		else $error("supply overvoltage did not pause");
	a_aux_delay: assert property (@(posedge core_clk) disable iff (!rst_b)
		aux_hit |-> $past(s.aux_over, 10))
		else $error("aux event without long enough high");
	a_ov5_pause: assert property (@(posedge core_clk) disable iff (!rst_b)
		(ov_trip && in_run && !hard_stop) |=> st_q == LEDFP_ST_PAUSE)
		else $error("aux count did not pause");
	a_brown_flag: assert property (@(posedge core_clk) disable iff (!rst_b)
		brown_hit |=> status.brownout_flag && status.stopped)
		else $error("brown-out not flagged");
	a_brown_exit: assert property (@(posedge core_clk) disable iff (!rst_b)
		(st_q == LEDFP_ST_STOP && brown_q_f && s.line_ok && s.supply_start
			&& !s.hot) |=> status.startup_consumption)
		else $error("brown-out exit not immediate");
	a_hot_stop: assert property (@(posedge core_clk) disable iff (!rst_b)
		s.hot |=> status.stopped)
		else $error("thermal trip did not stop");
	a_maxon_check: assert property (@(posedge core_clk) disable iff (!rst_b)
		(max_on && in_run && !hard_stop && !to_pause) |=> status.imp_check)
		else $error("no impedance check after max on-time");
	a_imp_stop: assert property (@(posedge core_clk) disable iff (!rst_b)
		(st_q == LEDFP_ST_CHECK && s.imp_done && s.imp_low) |=> status.stopped)
		else $error("shorted sense pin not stopped");
	a_cnt_clear: assert property (@(posedge core_clk) disable iff (!rst_b)
		to_pause |=> sc_cnt_q == 3'd0 && ov_cnt_q == 3'd0)
		else $error("fault counters not cleared");
endmodule : ledfp_top

// file: verification/ledfp_plant.sv
// power stage stand-in: current sense ramp and sense-pin check answers
`timescale 1ns/100ps
module ledfp_plant (
	input  wire logic       core_clk,
	input  wire logic       gate_drive,
	input  wire logic       imp_check,
	input  wire logic [3:0] lim_at,
	input  wire logic       short_en,
	input  wire logic       pin_short,
	output logic            limit_trip,
	output logic            short_trip,
	output logic            imp_done,
	output logic            imp_low
);
	logic [3:0] on_cnt;
	logic [2:0] chk_cnt;
	logic       junk;
	initial begin
		on_cnt = 4'h0;
		chk_cnt = 3'h0;
		junk = 1'b0;
	end
	always @(posedge core_clk) begin
		on_cnt <= gate_drive ? on_cnt + {3'h0, on_cnt != 4'hF} : 4'h0;
		chk_cnt <= imp_check ? chk_cnt + {2'h0, chk_cnt != 3'h7} : 3'h0;
		junk <= ~junk;
	end
	// zero lim_at models an open load: current never reaches the limit
	assign limit_trip = gate_drive && lim_at != 4'h0 && on_cnt >= lim_at;
	// a shorted winding overshoots early in the on-time
	assign short_trip = short_en && gate_drive && on_cnt >= 4'h2;
	assign imp_done = chk_cnt >= 3'h4;
	// result line is meaningless until the check is done
	assign imp_low = imp_done ? pin_short : junk;
endmodule : ledfp_plant

// file: verification/tb.sv
// self-checking bench for the led driver fault sequencer
`timescale 1ns/100ps
module tb;
	import ledfp_pkg::*;
	localparam int GD = 5, IC = 4, BO = 3, RP = 1, ST = 0;
	logic          core_clk, rst_b, cycle_start, zc_blank_done;
	logic          short_en, pin_short, lim, sht, idone, ilow;
	logic [3:0]    lim_at;
	ledfp_sense_t  drv, sense;
	ledfp_status_t status;
	int            failures, checked;
	always #50 core_clk = ~core_clk;
	always_comb begin
		sense = drv;
		sense.limit_trip = lim;
		sense.short_trip = sht;
		sense.imp_done = idone;
		sense.imp_low = ilow;
	end
	ledfp_top #(.TICK_CYC(10), .RECOVER_TKS(8), .BROWN_TKS(3)) i_dut (
		.core_clk(core_clk), .rst_b(rst_b), .cycle_start(cycle_start),
		.zc_blank_done(zc_blank_done), .sense(sense), .status(status));
	ledfp_plant i_plant (.core_clk(core_clk), .gate_drive(status.gate_drive),
		.imp_check(status.imp_check), .lim_at(lim_at), .short_en(short_en),
		.pin_short(pin_short), .limit_trip(lim), .short_trip(sht),
		.imp_done(idone), .imp_low(ilow));
	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask : tick
	task automatic chk(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// bounded wait for a status bit, then judge it
	task automatic wait_st(input int b, input logic v, input int lim_n);
		int n;
		n = 0;
		while (status[b] !== v && n < lim_n) begin
			tick(1);
			n++;
		end
		chk(status[b], v);
	endtask : wait_st
	task automatic cyc();
		cycle_start = 1'b1;
		tick(1);
		cycle_start = 1'b0;
	endtask : cyc
	task automatic recover();
		wait_st(RP, 0, 40);
		wait_st(IC, 1, 10);
		wait_st(IC, 0, 20);
	endtask : recover
	task automatic s_limit();
		cyc();
		wait_st(GD, 1, 4);
		wait_st(GD, 0, 12);
		tick(20);
		chk(status[GD], 1'b0);
	endtask : s_limit
	task automatic s_maxon();
		lim_at = 4'h0;
		cyc();
		tick(300);
		chk(status[GD], 1'b1);
		wait_st(IC, 1, 80);
		chk(status[GD], 1'b0);
		lim_at = 4'h4;
		wait_st(IC, 0, 20);
	endtask : s_maxon
	task automatic s_short();
		logic [7:0] pat;
		pat = 8'hF7; // three, one clean, then four in a row
		for (int i = 0; i < 8; i++) begin
			short_en = pat[i];
			cyc();
			tick(12);
			chk(status[RP], 1'b0);
		end
		short_en = 1'b0;
		cyc();
		wait_st(RP, 1, 6);
		cyc();
		tick(4);
		chk(status[GD], 1'b0);
		tick(56);
		chk(status[RP], 1'b1);
		recover();
	endtask : s_short
	task automatic s_ovp();
		lim_at = 4'h0;
		cyc();
		tick(5);
		drv.supply_over = 1'b1;
		wait_st(RP, 1, 6);
		chk(status[GD], 1'b0);
		drv.supply_over = 1'b0;
		lim_at = 4'h4;
		tick(60);
		chk(status[RP], 1'b1);
		recover();
	endtask : s_ovp
	task automatic s_aux();
		lim_at = 4'h2;
		for (int i = 0; i < 5; i++) begin
			cyc();
			tick(12);
			zc_blank_done = 1'b1;
			drv.aux_over = 1'b1;
			tick(i == 0 ? 9 : 14);
			drv.aux_over = 1'b0;
			zc_blank_done = 1'b0;
			chk(status[RP], 1'b0);
		end
		cyc();
		wait_st(RP, 1, 6);
		lim_at = 4'h4;
		tick(60);
		chk(status[RP], 1'b1);
		recover();
	endtask : s_aux
	task automatic s_brown();
		drv.line_ok = 1'b0;
		drv.line_low = 1'b1;
		tick(15);
		drv.line_low = 1'b0;
		tick(3);
		chk(status[BO], 1'b0);
		drv.line_low = 1'b1;
		wait_st(BO, 1, 50);
		chk(status[GD], 1'b0);
		drv.supply_start = 1'b0;
		drv.line_low = 1'b0;
		drv.line_ok = 1'b1;
		tick(10);
		chk(status[BO], 1'b1);
		drv.supply_start = 1'b1;
		wait_st(BO, 0, 6);
		wait_st(IC, 1, 10);
		wait_st(IC, 0, 20);
	endtask : s_brown
	task automatic s_hot();
		drv.hot = 1'b1;
		drv.cool = 1'b0;
		wait_st(ST, 1, 6);
		drv.hot = 1'b0;
		tick(10);
		chk(status[ST], 1'b1);
		pin_short = 1'b1;
		drv.cool = 1'b1;
		wait_st(ST, 0, 6);
		wait_st(IC, 1, 10);
		wait_st(ST, 1, 15);
		chk(status[GD], 1'b0);
	endtask : s_hot
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : conclude
	// whole run is about 1000 cycles; allow generous slack
	initial begin
		#500_000;
		failures++;
		conclude();
	end
	initial begin
		core_clk = 1'b0;
		rst_b = 1'b0;
		cycle_start = 1'b0;
		zc_blank_done = 1'b0;
		short_en = 1'b0;
		pin_short = 1'b0;
		lim_at = 4'h4;
		drv = '0;
		drv.line_ok = 1'b1;
		drv.cool = 1'b1;
		drv.supply_start = 1'b1;
		tick(6);
		rst_b = 1'b1;
		tick(1);
		chk(status.startup_consumption, 1'b1);
		wait_st(IC, 1, 10);
		wait_st(IC, 0, 20);
		s_limit();
		s_maxon();
		s_short();
		s_ovp();
		s_aux();
		s_brown();
		s_hot();
		conclude();
	end
endmodule : tb
